// *** rtl/crbp_port.sv ***
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
`include "crbp_consts.svh"
module crbp_port (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Converter core, same clock
    input wire crbp_pkg::crbp_conv_t conv,
    // Mode, test and send pins
    input wire logic mode_pin,
    input wire logic test_n_pin,
    input wire logic send_pin,
    // Status pin
    output logic status_pin,
    // Chip enable / load strobe pin
    input wire logic ce_load_pin,
    output crbp_pkg::crbp_pin_t ce_load,
    // Byte select / flag pins
    input wire logic low_byte_select_n_pin,
    output crbp_pkg::crbp_pin_t low_byte_select_n,
    input wire logic high_byte_select_n_pin,
    output crbp_pkg::crbp_pin_t high_byte_select_n,
    // Data lines: [11:0] magnitude, [12] sign, [13] overrange
    output logic [13:0] result_lines,
    output logic [13:0] result_lines_oe
);
    import crbp_pkg::*;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                                 input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // Pin synchronisers
    logic [5:0] pins_s;
    logic mode_s;
    logic test_n_s;
    logic send_s;
    logic ce_s;
    logic low_sel_n_s;
    logic high_sel_n_s;

    // Mode pulses shorter than a clock can slip past the sampler
    crbp_sync #(
        .W(6),
        .RST_VAL(`CRBP_SYNC_RST)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_level({mode_pin, test_n_pin, send_pin, ce_load_pin, low_byte_select_n_pin, high_byte_select_n_pin}),
        .synced(pins_s)
    );

    assign {mode_s, test_n_s, send_s, ce_s, low_sel_n_s, high_sel_n_s} = pins_s;

    // Bus and register state
    logic port_en;
    logic next_port_en;
    logic [7:0] strobe_cycles;
    logic [7:0] next_strobe_cycles;
    logic result_new;
    logic next_result_new;
    crbp_result_t result;
    crbp_result_t next_result;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic wr_take;
    logic [31:0] ctrl_word;
    logic [31:0] strobe_word;
    logic [31:0] ctrl_merged;
    logic [31:0] strobe_merged;

    // Handshake state
    crbp_hs_t hs_state;
    crbp_hs_t next_hs_state;
    logic [7:0] hs_cnt;
    logic [7:0] next_hs_cnt;
    crbp_result_t hs_data;
    crbp_result_t next_hs_data;
    logic mode_prev;
    logic next_mode_prev;
    logic hs_start;
    logic load_done;

    // Pin output state
    logic next_status;
    crbp_pin_t next_ce_load;
    crbp_pin_t next_low_sel;
    crbp_pin_t next_high_sel;
    logic [13:0] next_lines;
    logic [13:0] next_lines_oe;

    // Write lands at the edge that ends the cycle after the wait state
    assign wr_take = write && !waitrequest;
    assign ctrl_word = {31'h0, port_en};
    assign strobe_word = {24'h0, strobe_cycles};
    assign ctrl_merged = merge_bytes(ctrl_word, writedata, byteenable);
    assign strobe_merged = merge_bytes(strobe_word, writedata, byteenable);

    // Bus: request held one cycle under waitrequest, answered on the next
    always_comb begin
        next_waitrequest = 1'b1;
        next_readdata = readdata;
        next_port_en = port_en;
        next_strobe_cycles = strobe_cycles;
        next_result = result;
        next_result_new = result_new;
        if ((read || write) && waitrequest) begin
            next_waitrequest = 1'b0;
            next_readdata = 32'h0;
            if (read) begin
                unique case (address)
                    `CRBP_REG_RESULT: next_readdata = {18'h0, result};
                    `CRBP_REG_STATE: begin
                        next_readdata[`CRBP_ST_MODE] = mode_s;
                        next_readdata[`CRBP_ST_BUSY] = hs_state != CRBP_HS_IDLE;
                        next_readdata[`CRBP_ST_STATUS] = status_pin;
                        next_readdata[`CRBP_ST_TEST] = !test_n_s;
                        next_readdata[`CRBP_ST_NEW] = result_new;
                    end
                    `CRBP_REG_CTRL: next_readdata = ctrl_word;
                    `CRBP_REG_STROBE: next_readdata = strobe_word;
                    default: next_readdata = 32'h0;
                endcase
            end
        end
        if (wr_take) begin
            unique case (address)
                `CRBP_REG_CTRL: next_port_en = ctrl_merged[`CRBP_CTRL_PORT_EN];
                `CRBP_REG_STROBE: next_strobe_cycles = strobe_merged[7:0];
                `CRBP_REG_STATE: begin
                    if (byteenable[0] && writedata[`CRBP_ST_NEW]) begin
                        next_result_new = 1'b0;
                    end
                end
                default: next_port_en = port_en;
            endcase
        end
        // Latch wins over a software clear in the same cycle
        if (conv.valid) begin
            next_result = conv.result;
            next_result_new = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
            port_en <= `CRBP_CTRL_RST;
            strobe_cycles <= 8'(`CRBP_LOAD_CYC);
            result <= '0;
            result_new <= 1'b0;
        end else begin
            waitrequest <= next_waitrequest;
            readdata <= next_readdata;
            port_en <= next_port_en;
            strobe_cycles <= next_strobe_cycles;
            result <= next_result;
            result_new <= next_result_new;
        end
    end

    // Handshake sequencer
    assign hs_start = (mode_s && !mode_prev) || (mode_s && conv.valid);
    // Zero length behaves as one so a load strobe never vanishes
    assign load_done = ({1'b0, hs_cnt} + 9'h001) >= {1'b0, strobe_cycles};

    always_comb begin
        next_hs_state = hs_state;
        next_hs_cnt = hs_cnt;
        next_hs_data = hs_data;
        next_mode_prev = mode_s;
        unique case (hs_state)
            CRBP_HS_IDLE: begin
                if (hs_start) begin
                    // A result latched in this cycle goes out, not the stale one
                    next_hs_data = conv.valid ? conv.result : result;
                    next_hs_state = CRBP_HS_HIGH_WAIT;
                end
            end
            CRBP_HS_HIGH_WAIT: begin
                next_hs_cnt = 8'h00;
                if (send_s) begin
                    next_hs_state = CRBP_HS_HIGH_LOAD;
                end
            end
            CRBP_HS_HIGH_LOAD: begin
                next_hs_cnt = hs_cnt + 8'h01;
                if (load_done) begin
                    next_hs_state = CRBP_HS_LOW_WAIT;
                end
            end
            CRBP_HS_LOW_WAIT: begin
                next_hs_cnt = 8'h00;
                if (send_s) begin
                    next_hs_state = CRBP_HS_LOW_LOAD;
                end
            end
            CRBP_HS_LOW_LOAD: begin
                next_hs_cnt = hs_cnt + 8'h01;
                if (load_done) begin
                    next_hs_state = CRBP_HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hs_state <= CRBP_HS_IDLE;
            hs_cnt <= 8'h00;
            hs_data <= '0;
            mode_prev <= 1'b0;
        end else begin
            hs_state <= next_hs_state;
            hs_cnt <= next_hs_cnt;
            hs_data <= next_hs_data;
            mode_prev <= next_mode_prev;
        end
    end

    // Pin drivers, all registered so the pads see no decode glitches
    always_comb begin
        next_status = (conv.phase != CRBP_AUTO_ZERO) && !conv.valid;
        next_ce_load = '{drive: 1'b1, oe: 1'b0};
        next_low_sel = '{drive: 1'b1, oe: 1'b0};
        next_high_sel = '{drive: 1'b1, oe: 1'b0};
        next_lines = {result.overrange, result.sign_flag, result.magnitude};
        next_lines_oe = 14'h0;
        if (hs_state != CRBP_HS_IDLE || mode_s) begin
            // Control pins turn round as outputs, idle high
            next_ce_load.oe = 1'b1;
            next_low_sel.oe = 1'b1;
            next_high_sel.oe = 1'b1;
            next_lines = {hs_data.overrange, hs_data.sign_flag, hs_data.magnitude};
            unique case (hs_state)
                CRBP_HS_HIGH_WAIT: begin
                    next_high_sel.drive = 1'b0;
                    next_lines_oe[13:8] = {`CRBP_HIGH_LINES{port_en}};
                end
                CRBP_HS_HIGH_LOAD: begin
                    next_high_sel.drive = 1'b0;
                    next_ce_load.drive = 1'b0;
                    next_lines_oe[13:8] = {`CRBP_HIGH_LINES{port_en}};
                end
                CRBP_HS_LOW_WAIT: begin
                    next_low_sel.drive = 1'b0;
                    next_lines_oe[7:0] = {`CRBP_LOW_LINES{port_en}};
                end
                CRBP_HS_LOW_LOAD: begin
                    next_low_sel.drive = 1'b0;
                    next_ce_load.drive = 1'b0;
                    next_lines_oe[7:0] = {`CRBP_LOW_LINES{port_en}};
                end
                CRBP_HS_IDLE: next_lines_oe = 14'h0;
            endcase
        end else if (!ce_s) begin
            next_lines_oe[7:0] = {`CRBP_LOW_LINES{port_en && !low_sel_n_s}};
            next_lines_oe[13:8] = {`CRBP_HIGH_LINES{port_en && !high_sel_n_s}};
        end
        if (!test_n_s) begin
            // Drivers forced on so the forced level is seen on every line
            next_lines = 14'h3fff;
            next_lines_oe = 14'h3fff;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_pin <= 1'b0;
            ce_load <= '{drive: 1'b1, oe: 1'b0};
            low_byte_select_n <= '{drive: 1'b1, oe: 1'b0};
            high_byte_select_n <= '{drive: 1'b1, oe: 1'b0};
            result_lines <= 14'h0;
            result_lines_oe <= 14'h0;
        end else begin
            status_pin <= next_status;
            ce_load <= next_ce_load;
            low_byte_select_n <= next_low_sel;
            high_byte_select_n <= next_high_sel;
            result_lines <= next_lines;
            result_lines_oe <= next_lines_oe;
        end
    end
endmodule : crbp_port

// *** rtl/crbp_consts.svh ***
`ifndef CRBP_CONSTS_SVH
`define CRBP_CONSTS_SVH

// Register byte offsets
`define CRBP_REG_RESULT 4'h0
`define CRBP_REG_STATE 4'h4
`define CRBP_REG_CTRL 4'h8
`define CRBP_REG_STROBE 4'hc

// State register fields
`define CRBP_ST_MODE 0
`define CRBP_ST_BUSY 1
`define CRBP_ST_STATUS 2
`define CRBP_ST_TEST 3
`define CRBP_ST_NEW 4

// Control register fields and reset values
`define CRBP_CTRL_PORT_EN 0
`define CRBP_CTRL_RST 1'b1

// Byte split of the fourteen data lines
`define CRBP_LOW_LINES 8
`define CRBP_HIGH_LINES 6

// Load strobe timing
`define CRBP_CLK_MHZ 250
`define CRBP_LOAD_NS 40
`define CRBP_LOAD_CYC ((`CRBP_LOAD_NS * `CRBP_CLK_MHZ + 999) / 1000)

// Pin synchroniser reset image {mode, test_n, send, ce_load, low_sel_n, high_sel_n}
`define CRBP_SYNC_RST 6'h1f
`endif

// *** rtl/crbp_pkg.sv ***
package crbp_pkg;

    typedef struct packed {
        logic overrange;
        logic sign_flag;
        logic [11:0] magnitude;
    } crbp_result_t;

    typedef enum logic [1:0] {
        CRBP_AUTO_ZERO,
        CRBP_INTEGRATE,
        CRBP_DEINTEGRATE
    } crbp_phase_t;

    typedef struct packed {
        logic valid;
        crbp_phase_t phase;
        crbp_result_t result;
    } crbp_conv_t;

    typedef enum logic [2:0] {
        CRBP_HS_IDLE,
        CRBP_HS_HIGH_WAIT,
        CRBP_HS_HIGH_LOAD,
        CRBP_HS_LOW_WAIT,
        CRBP_HS_LOW_LOAD
    } crbp_hs_t;

    typedef struct packed {
        logic drive;
        logic oe;
    } crbp_pin_t;

endpackage : crbp_pkg

// *** rtl/crbp_sync.sv ***
`timescale 1ns/100ps
module crbp_sync #(
    parameter int W = 6,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins
    input wire logic [W-1:0] async_level,
    output logic [W-1:0] synced
);
    logic [W-1:0] first_stage;
    logic [W-1:0] next_first_stage;
    logic [W-1:0] next_synced;

    always_comb begin
        next_first_stage = async_level;
        next_synced = first_stage;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            first_stage <= RST_VAL;
            synced <= RST_VAL;
        end else begin
            first_stage <= next_first_stage;
            synced <= next_synced;
        end
    end
endmodule : crbp_sync

// *** verification/crbp_port_properties.sv ***
`timescale 1ns/100ps
`include "crbp_consts.svh"
module crbp_port_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Converter and pins
    input wire crbp_pkg::crbp_conv_t conv,
    input wire logic mode_pin,
    input wire logic test_n_pin,
    input wire logic send_pin,
    input wire logic status_pin,
    input wire logic ce_load_pin,
    input wire crbp_pkg::crbp_pin_t ce_load,
    input wire logic low_byte_select_n_pin,
    input wire crbp_pkg::crbp_pin_t low_byte_select_n,
    input wire logic high_byte_select_n_pin,
    input wire crbp_pkg::crbp_pin_t high_byte_select_n,
    input wire logic [13:0] result_lines,
    input wire logic [13:0] result_lines_oe
);
    import crbp_pkg::*;
    localparam int LOAD_CYC = `CRBP_LOAD_CYC;
    logic [7:0] load_len;
    logic [7:0] next_load_len;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    always_comb begin
        next_load_len = (ce_load.oe && !ce_load.drive) ? load_len + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk) begin
        load_len <= rst ? 8'h00 : next_load_len;
    end
    sequence s_high_load;
        !high_byte_select_n.drive && !ce_load.drive && ce_load.oe;
    endsequence
    sequence s_high_done;
        $rose(high_byte_select_n.drive) && high_byte_select_n.oe;
    endsequence
    // Five samples cover two sync flops plus the output register
    AST_CE_MASTER: assert property ((ce_load_pin && !mode_pin && test_n_pin && !ce_load.oe)[*5]
        |-> result_lines_oe == 14'h0000) else $error("data lines driven while chip enable high");
    AST_TEST_FORCE: assert property ((!test_n_pin)[*5]
        |-> result_lines == 14'h3fff && result_lines_oe == 14'h3fff) else $error("test low not forcing lines high");
    AST_MODE_OUT: assert property (mode_pin[*5]
        |-> ce_load.oe && low_byte_select_n.oe && high_byte_select_n.oe) else $error("control pins not outputs");
    AST_STATUS: assert property (1'b1 |=> status_pin == ($past(conv.phase) != CRBP_AUTO_ZERO && !$past(conv.valid)))
        else $error("status pin wrong for phase");
    AST_BUS_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one wait cycle");
    AST_UNMAPPED: assert property (read && waitrequest && address[1:0] != 2'b00 |=> readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_HIGH_LOAD: assert property (s_high_load |-> low_byte_select_n.drive && result_lines_oe[13:8] == 6'h3f)
        else $error("high byte load malformed");
    AST_HIGH_THEN_LOW: assert property (s_high_done |-> !low_byte_select_n.drive)
        else $error("low byte not following high byte");
    AST_LOAD_LEN: assert property ($rose(ce_load.drive) && $past(ce_load.oe) |-> load_len == 8'(LOAD_CYC))
        else $error("load strobe length wrong");
    AST_LOW_ONLY: assert property ((!mode_pin && !ce_load_pin && high_byte_select_n_pin && !ce_load.oe)[*5]
        |-> result_lines_oe[13:8] == 6'h00 || !test_n_pin) else $error("high byte driven without select");
    // Two sync flops, state register and pin register lie between send and the strobe
    AST_SEND_PACED: assert property ($fell(ce_load.drive) && ce_load.oe |-> $past(send_pin, 4))
        else $error("load strobe started without send");
endmodule : crbp_port_properties

// *** verification/crbp_partner.sv ***
`timescale 1ns/100ps
module crbp_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Device pins
    input wire crbp_pkg::crbp_pin_t ce_load,
    input wire crbp_pkg::crbp_pin_t high_byte_select_n,
    input wire logic [13:0] result_lines,
    // Pacing and capture
    input wire logic slow,
    output logic send_pin,
    output logic got,
    output logic [7:0] got_byte
);
    import crbp_pkg::*;
    logic load_d;
    int hold;
    always_ff @(posedge clk) begin
        load_d <= ce_load.oe && !ce_load.drive;
        got <= 1'b0;
        if (rst) begin
            send_pin <= 1'b1;
            hold <= 0;
        end else if (ce_load.oe && !ce_load.drive && !load_d) begin
            got <= 1'b1;
            got_byte <= !high_byte_select_n.drive ? {2'b00, result_lines[13:8]} : result_lines[7:0];
            // Send held low past the strobe so the next byte really stalls
            if (slow) begin
                send_pin <= 1'b0;
                hold <= 20;
            end
        end else if (hold > 1) begin
            hold <= hold - 1;
        end else begin
            send_pin <= 1'b1;
            hold <= 0;
        end
    end
endmodule : crbp_partner

// *** verification/crbp_port_tb.sv ***
`timescale 1ns/100ps
`include "crbp_consts.svh"
`define CMP(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module crbp_port_tb;
    import crbp_pkg::*;
    logic clk, rst, read, write, test_n_pin, mode_pin, host_ce, host_lo, host_hi, slow, got, smp, send_pin;
    logic status_pin, waitrequest;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, obs, ex;
    logic [31:0] exq[$];
    logic [7:0] got_byte;
    logic [13:0] result_lines, result_lines_oe, r;
    crbp_conv_t conv;
    crbp_pin_t ce_load, lo_sel, hi_sel;
    int n_errors, compares, cyc;
    // Device wins the pin while it enables its driver
    wire logic ce_pin = ce_load.oe ? ce_load.drive : host_ce;
    wire logic lo_pin = lo_sel.oe ? lo_sel.drive : host_lo;
    wire logic hi_pin = hi_sel.oe ? hi_sel.drive : host_hi;
    crbp_port crbp_port_i (.clk, .rst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
        .conv, .mode_pin, .test_n_pin, .send_pin, .status_pin, .ce_load_pin(ce_pin), .ce_load,
        .low_byte_select_n_pin(lo_pin), .low_byte_select_n(lo_sel), .high_byte_select_n_pin(hi_pin),
        .high_byte_select_n(hi_sel), .result_lines, .result_lines_oe);
    crbp_partner crbp_partner_i (.clk, .rst, .ce_load, .high_byte_select_n(hi_sel), .result_lines, .slow,
        .send_pin, .got, .got_byte);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            end_sim();
        end
    end
    always @(posedge clk) begin
        if ((read && !waitrequest) || got || smp) begin
            obs = (read && !waitrequest) ? readdata : got ? {24'h0, got_byte}
                : {4'h0, result_lines_oe, result_lines & result_lines_oe};
            ex = (exq.size() != 0) ? exq.pop_front() : ~obs;
            `CMP(obs, ex)
        end
    end
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic sample(input logic [31:0] e);
        exq.push_back(e);
        smp <= 1'b1;
        @(posedge clk);
        smp <= 1'b0;
    endtask : sample
    task automatic pins(input logic [2:0] p, input logic t);
        {host_ce, host_hi, host_lo} <= p;
        test_n_pin <= t;
        repeat (5) @(posedge clk);
    endtask : pins
    task automatic convert(input logic [13:0] v);
        conv.phase <= CRBP_INTEGRATE;
        repeat (3) @(posedge clk);
        conv.phase <= CRBP_DEINTEGRATE;
        conv.result <= v;
        conv.valid <= 1'b1;
        @(posedge clk);
        conv.valid <= 1'b0;
        conv.phase <= CRBP_AUTO_ZERO;
        @(posedge clk);
    endtask : convert
    task automatic hs_exp(input logic [13:0] v);
        exq.push_back({26'h0, v[13:8]});
        exq.push_back({24'h0, v[7:0]});
    endtask : hs_exp
    task automatic hs_wait();
        for (int i = 0; i < 500 && exq.size() != 0; i++) @(posedge clk);
        `CMP(32'(exq.size()), 32'h0)
        repeat (6) @(posedge clk);
    endtask : hs_wait
    function automatic logic [31:0] exp_direct(input logic [2:0] p, input logic [13:0] v);
        logic [13:0] oe;
        oe = p[2] ? 14'h0 : {{6{!p[1]}}, {8{!p[0]}}};
        return {4'h0, oe, v & oe};
    endfunction : exp_direct
    initial begin
        rst = 1'b1;
        {read, write, smp, slow, mode_pin} = '0;
        {host_ce, host_hi, host_lo, test_n_pin} = 4'hf;
        address = 4'h0;
        writedata = 32'h0;
        byteenable = 4'hf;
        conv = '0;
        n_errors = 0;
        compares = 0;
        cyc = 0;
        r = 14'($urandom(8));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`CRBP_REG_CTRL, 32'h1);
        rd(4'h2, 32'h0);
        convert(r);
        rd(`CRBP_REG_STATE, 32'h10);
        bus(1'b1, `CRBP_REG_STATE, 32'h10);
        rd(`CRBP_REG_STATE, 32'h0);
        rd(`CRBP_REG_RESULT, {18'h0, r});
        bus(1'b1, `CRBP_REG_RESULT, 32'h0);
        rd(`CRBP_REG_RESULT, {18'h0, r});
        bus(1'b1, `CRBP_REG_STROBE, 32'h05);
        rd(`CRBP_REG_STROBE, 32'h05);
        bus(1'b1, `CRBP_REG_STROBE, 32'(`CRBP_LOAD_CYC));
        for (int p = 0; p < 8; p++) begin
            r = 14'($urandom());
            convert(r);
            pins(p[2:0], 1'b1);
            sample(exp_direct(p[2:0], r));
        end
        pins(3'b111, 1'b0);
        sample({4'h0, 14'h3fff, 14'h3fff});
        bus(1'b1, `CRBP_REG_CTRL, 32'h0);
        pins(3'b000, 1'b1);
        sample(32'h0);
        bus(1'b1, `CRBP_REG_CTRL, 32'h1);
        pins(3'b111, 1'b1);
        slow <= 1'b1;
        hs_exp(r);
        mode_pin <= 1'b1;
        repeat (20) @(posedge clk);
        mode_pin <= 1'b0;
        hs_wait();
        slow <= 1'b0;
        hs_exp(r);
        mode_pin <= 1'b1;
        hs_wait();
        r = 14'($urandom());
        hs_exp(r);
        convert(r);
        hs_wait();
        end_sim();
    end
endmodule : crbp_port_tb
bind crbp_port crbp_port_properties crbp_port_properties_i (.clk, .rst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .conv, .mode_pin, .test_n_pin, .send_pin, .status_pin, .ce_load_pin,
    .ce_load, .low_byte_select_n_pin, .low_byte_select_n, .high_byte_select_n_pin, .high_byte_select_n,
    .result_lines, .result_lines_oe);
